// ### verilog/sram_port_consts.svh
// Constants of the flow-through burst SRAM port
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SRAM_ADDR_W 18
`define SRAM_DATA_W 18
`define SRAM_LANES 2
`define SRAM_LANE_W 9
`define SRAM_BURST_W 2
`define SRAM_FIFO_DEPTH 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRAM_RST_ADDR 18'h00000
`define SRAM_RST_DATA 18'h00000
`define SRAM_RST_CNT 2'h0

`endif

// ### verilog/sram_port_pkg.sv
// Types of the SRAM port, including the entry layout it pushes into its write buffer
`include "sram_port_consts.svh"
package sram_port_pkg;

  typedef enum logic [1:0] {ST_DESEL, ST_READ, ST_WRITE} op_e;

  typedef struct packed {
    logic [`SRAM_ADDR_W-1:0] addr;
    logic [`SRAM_DATA_W-1:0] data;
    logic [`SRAM_LANES-1:0] bw_n;
  } wr_entry_s;

endpackage : sram_port_pkg

// ### verilog/sram_wr_fifo.sv
// Write buffer between the pin pipeline and the array
`timescale 1ns/1ps
module sram_wr_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("sram_wr_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  assign o_in_ready = (count_ff != (PW+1)'(DEPTH));
  assign o_out_valid = (count_ff != '0);
  assign o_out_data = mem_ff[rd_ptr_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // ----------------------------------------
  // Storage, not reset: data only
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : sram_wr_fifo

// ### verilog/flow_through_burst_sram_port.sv
// Flow-through burst SRAM core: pin pipeline, burst counter, array, data drivers
`timescale 1ns/1ps
`include "sram_port_consts.svh"
module flow_through_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [`SRAM_ADDR_W-1:0] I_ADDR,
  input wire logic I_WRITE_N,
  input wire logic [`SRAM_LANES-1:0] I_BYTE_WRITE_SELECT_N,
  input wire logic I_CHIP_SELECT1_N,
  input wire logic I_CHIP_SELECT2,
  input wire logic I_CHIP_SELECT3_N,
  input wire logic I_BURST_ADVANCE_LOAD,
  input wire logic I_CLOCK_QUALIFIER_N,
  input wire logic I_OUTPUT_ENABLE_N,
  input wire logic I_BURST_INTERLEAVED,
  input wire logic [`SRAM_DATA_W-1:0] I_DQ,
  output logic [`SRAM_DATA_W-1:0] O_DQ,
  output logic O_DQ_OE
);
  localparam int BW = `SRAM_BURST_W;
  localparam int LW = `SRAM_LANE_W;

  generate
    if (DATA_W != `SRAM_DATA_W || ADDR_W > `SRAM_ADDR_W || ADDR_W <= BW) begin : g_bad
      $error("flow_through_burst_sram_port: unsupported ADDR_W or DATA_W");
    end
  endgenerate

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] base,
                                              input logic [BW-1:0] cnt,
                                              input logic inter);
    burst_low = inter ? (base ^ cnt) : (base + cnt);
  endfunction : burst_low

  function automatic logic lane_we(input logic [`SRAM_LANES-1:0] bw_n, input int lane);
    lane_we = ~bw_n[lane];
  endfunction : lane_we

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_s1_ff;
  logic rst_n;
  logic [2:0] oe_s_ff;
  logic [2:0] mode_s_ff;
  logic oe_n_ff;
  logic inter_ff;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  // Output enable is asynchronous at the pin; it costs four cycles of latency here
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      oe_s_ff <= 3'h7;
      mode_s_ff <= 3'h0;
      oe_n_ff <= 1'b1;
      inter_ff <= 1'b0;
    end else begin
      oe_s_ff <= {oe_s_ff[1:0], I_OUTPUT_ENABLE_N};
      mode_s_ff <= {mode_s_ff[1:0], I_BURST_INTERLEAVED};
      if (oe_s_ff[1] == oe_s_ff[2]) begin
        oe_n_ff <= oe_s_ff[2];
      end
      if (mode_s_ff[1] == mode_s_ff[2]) begin
        inter_ff <= mode_s_ff[2];
      end
    end
  end

  // ----------------------------------------
  // Command decode and burst counter
  // ----------------------------------------
  op_e op_ff;
  op_e nxt_op;
  logic [ADDR_W-1:0] base_ff;
  logic [ADDR_W-1:0] nxt_base;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [ADDR_W-1:0] addr_in;
  logic [BW-1:0] cnt_ff;
  logic [BW-1:0] nxt_cnt;
  logic selected;
  logic stall;
  logic fifo_in_ready;

  assign addr_in = I_ADDR[ADDR_W-1:0];
  assign selected = ~I_CHIP_SELECT1_N & I_CHIP_SELECT2 & ~I_CHIP_SELECT3_N;
  // A full write buffer stalls like the qualifier; it cannot fill while both run together
  assign stall = I_CLOCK_QUALIFIER_N | ~fifo_in_ready;

  always_comb begin
    nxt_op = op_ff;
    nxt_base = base_ff;
    nxt_cnt = cnt_ff + 1'b1;
    if (!I_BURST_ADVANCE_LOAD) begin
      nxt_base = addr_in;
      nxt_cnt = '0;
      if (!selected) begin
        nxt_op = ST_DESEL;
      end else if (!I_WRITE_N) begin
        nxt_op = ST_WRITE;
      end else begin
        nxt_op = ST_READ;
      end
    end
    nxt_addr = {nxt_base[ADDR_W-1:BW], burst_low(nxt_base[BW-1:0], nxt_cnt, inter_ff)};
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= ST_DESEL;
      base_ff <= '0;
      addr_ff <= '0;
      cnt_ff <= `SRAM_RST_CNT;
    end else if (!stall) begin
      op_ff <= nxt_op;
      base_ff <= nxt_base;
      addr_ff <= nxt_addr;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // Write path through the buffer
  // ----------------------------------------
  wr_entry_s push_entry;
  wr_entry_s head;
  logic push_valid;
  logic head_valid;
  logic pop;
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Data and byte selects of a write arrive one qualified edge after its address
  assign push_valid = (op_ff == ST_WRITE) & ~I_CLOCK_QUALIFIER_N;
  assign push_entry = '{addr: `SRAM_ADDR_W'(addr_ff), data: I_DQ,
                        bw_n: I_BYTE_WRITE_SELECT_N};
  assign pop = head_valid & ~I_CLOCK_QUALIFIER_N;

  sram_wr_fifo #(
    .WIDTH($bits(wr_entry_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_in_valid(push_valid),
    .i_in_data(push_entry),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(head_valid),
    .i_out_ready(~I_CLOCK_QUALIFIER_N),
    .o_out_data(head)
  );

  // Self-timed array write: one buffered entry per qualified edge
  always_ff @(posedge I_CLK) begin
    if (pop) begin
      for (int l = 0; l < `SRAM_LANES; l++) begin
        if (lane_we(head.bw_n, l)) begin
          mem[head.addr[ADDR_W-1:0]][l*LW +: LW] <= head.data[l*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------
  // Read path with forwarding of writes not yet in the array
  // ----------------------------------------
  logic push_hit;
  logic head_hit;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] arr_word;

  assign arr_word = mem[nxt_addr];
  assign push_hit = push_valid & (addr_ff == nxt_addr);
  assign head_hit = head_valid & (head.addr[ADDR_W-1:0] == nxt_addr);

  generate
    for (genvar g = 0; g < `SRAM_LANES; g++) begin : g_fwd
      assign rd_word[g*LW +: LW] =
        (push_hit && lane_we(I_BYTE_WRITE_SELECT_N, g)) ? I_DQ[g*LW +: LW] :
        (head_hit && lane_we(head.bw_n, g)) ? head.data[g*LW +: LW] :
        arr_word[g*LW +: LW];
    end
  endgenerate

  logic [DATA_W-1:0] dq_ff;
  logic drive_ff;
  logic dq_oe_ff;
  logic nxt_drive;

  // Only a read cycle drives; write data, deselect and emerging cycles stay off
  assign nxt_drive = stall ? drive_ff : (nxt_op == ST_READ);

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dq_ff <= `SRAM_RST_DATA;
      drive_ff <= 1'b0;
    end else if (!stall) begin
      // Load only on reads, so write and deselect cycles leave the last read word in the output register
      if (nxt_op == ST_READ) begin
        dq_ff <= rd_word;
      end
      drive_ff <= nxt_drive;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= nxt_drive & ~oe_n_ff;
    end
  end

  assign O_DQ = dq_ff;
  assign O_DQ_OE = dq_oe_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [ADDR_W-1:0] head_addr;
  logic [DATA_W-1:0] head_data;
  assign head_addr = head.addr[ADDR_W-1:0];
  assign head_data = head.data;

  property p_load;
    @(posedge I_CLK) disable iff (!rst_n)
      (!stall && !I_BURST_ADVANCE_LOAD) |=> (base_ff == $past(addr_in)) && (cnt_ff == '0);
  endproperty
  a_load: assert property (p_load) else $error("address not loaded");

  property p_hold;
    @(posedge I_CLK) disable iff (!rst_n)
      stall |=> $stable(op_ff) && $stable(addr_ff) && $stable(O_DQ) && $stable(cnt_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved on a suspended edge");

  property p_advance;
    @(posedge I_CLK) disable iff (!rst_n)
      (!stall && I_BURST_ADVANCE_LOAD) |=> (cnt_ff == BW'($past(cnt_ff) + 1'b1));
  endproperty
  a_advance: assert property (p_advance) else $error("burst counter did not step");

  property p_write_quiet;
    @(posedge I_CLK) disable iff (!rst_n)
      (op_ff == ST_WRITE) |-> !O_DQ_OE;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drivers on in write");

  property p_desel_quiet;
    @(posedge I_CLK) disable iff (!rst_n)
      (op_ff == ST_DESEL) |-> !O_DQ_OE;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("drivers on deselected");

  property p_oe_gate;
    @(posedge I_CLK) disable iff (!rst_n)
      oe_n_ff |=> !O_DQ_OE;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("output enable ignored");

  property p_turn;
    @(posedge I_CLK) disable iff (!rst_n)
      (!stall && op_ff == ST_WRITE && nxt_op == ST_READ) |=> drive_ff && $stable(fifo_in_ready);
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround cycle inserted");

  property p_flow;
    @(posedge I_CLK) disable iff (!rst_n)
      (!stall && nxt_op == ST_READ && !push_hit && !head_hit) |=> (O_DQ == mem[$past(nxt_addr)]);
  endproperty
  a_flow: assert property (p_flow) else $error("read data not from array");

  property p_lane0;
    @(posedge I_CLK) disable iff (!rst_n)
      (pop && !head.bw_n[0]) |=> (mem[$past(head_addr)][LW-1:0] == $past(head_data[LW-1:0]));
  endproperty
  a_lane0: assert property (p_lane0) else $error("lane 0 not written");

  property p_lane1;
    @(posedge I_CLK) disable iff (!rst_n)
      (pop && !head.bw_n[1]) |=> (mem[$past(head_addr)][2*LW-1:LW] == $past(head_data[2*LW-1:LW]));
  endproperty
  a_lane1: assert property (p_lane1) else $error("lane 1 not written");

  property p_read_drive;
    @(posedge I_CLK) disable iff (!rst_n)
      (!stall && nxt_op == ST_READ && !oe_n_ff) |=> O_DQ_OE;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read cycle not driven");

endmodule : flow_through_burst_sram_port

// ### testbench/sram_ctrl_model.sv
// Controller-side model driving the command and write-data pins of the SRAM port
`timescale 1ns/1ps
module sram_ctrl_model (
  input wire logic i_clk,
  output logic [17:0] o_addr,
  output logic o_write_n,
  output logic [1:0] o_bw_n,
  output logic [2:0] o_cs,
  output logic o_adv,
  output logic o_qual_n,
  output logic [17:0] o_dq
);
  logic wr_pend = 1'b0;
  logic [17:0] pend_d;
  logic [1:0] pend_bw;
  initial begin
    o_addr = 18'h00000;
    o_write_n = 1'b1;
    o_bw_n = 2'h3;
    o_cs = 3'h0;
    o_adv = 1'b0;
    o_qual_n = 1'b0;
    o_dq = 18'h00000;
  end
  // Launched just after an edge; one command per qualified edge
  task automatic step(input logic [2:0] c, input logic we_n, input logic ad,
      input logic [17:0] a, input logic [17:0] d, input logic [1:0] bw, input logic is_wr);
    o_cs = c;
    o_write_n = we_n;
    o_adv = ad;
    o_addr = a;
    o_qual_n = 1'b0;
    // Idle bus shows the inverse, so a stale value never passes for data
    o_dq = wr_pend ? pend_d : ~o_dq;
    o_bw_n = wr_pend ? pend_bw : 2'h3;
    wr_pend = is_wr;
    pend_d = d;
    pend_bw = bw;
    @(posedge i_clk);
    #1;
  endtask : step
  // Slow answer: one suspended cycle, every other pin held
  task automatic stall();
    o_qual_n = 1'b1;
    @(posedge i_clk);
    #1;
  endtask : stall
endmodule : sram_ctrl_model

// ### testbench/flow_through_burst_sram_port_test.sv
// Self-checking bench for the flow-through burst SRAM port
`timescale 1ns/1ps
module flow_through_burst_sram_port_test;
  localparam int AW = 6;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic oe_n = 1'b0;
  logic inter = 1'b0;
  logic [17:0] addr, dq_in, dq_out, base;
  logic [1:0] bw_n, cnt;
  logic [2:0] cs;
  logic write_n, adv, qual_n, dq_oe, sel, wr;
  logic [17:0] mem [64];
  logic [2:0] dsel [4] = '{3'b011, 3'b000, 3'b110, 3'b111};
  logic [31:0] r, q;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 26;
  always #20 clk = ~clk;
  sram_ctrl_model ctl (.i_clk(clk), .o_addr(addr), .o_write_n(write_n), .o_bw_n(bw_n),
    .o_cs(cs), .o_adv(adv), .o_qual_n(qual_n), .o_dq(dq_in));
  flow_through_burst_sram_port #(.ADDR_W(AW)) uut (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_ADDR(addr), .I_WRITE_N(write_n), .I_BYTE_WRITE_SELECT_N(bw_n),
    .I_CHIP_SELECT1_N(cs[2]), .I_CHIP_SELECT2(cs[1]), .I_CHIP_SELECT3_N(cs[0]),
    .I_BURST_ADVANCE_LOAD(adv), .I_CLOCK_QUALIFIER_N(qual_n), .I_OUTPUT_ENABLE_N(oe_n),
    .I_BURST_INTERLEAVED(inter), .I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE(dq_oe));
  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [17:0] baddr(input logic [17:0] b, input logic [1:0] n,
      input logic il);
    return {b[17:2], il ? b[1:0] ^ n : b[1:0] + n};
  endfunction : baddr
  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] d,
      input logic [1:0] bw);
    return {bw[1] ? o[17:9] : d[17:9], bw[0] ? o[8:0] : d[8:0]};
  endfunction : merge
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One command, its checks, and now and then a suspended cycle
  task automatic op(input logic [2:0] c, input logic we_n, input logic ad,
      input logic [17:0] a, input logic [17:0] d, input logic [1:0] bw);
    logic [17:0] ea;
    logic [17:0] hold_dq;
    logic hold_oe;
    if (!ad) begin
      sel = (c == 3'b010);
      wr = !we_n;
      base = a;
      cnt = 2'h0;
    end else begin
      cnt = cnt + 2'h1;
    end
    ea = baddr(base, cnt, inter);
    if (sel && wr) mem[ea[5:0]] = merge(mem[ea[5:0]], d, bw);
    ctl.step(c, we_n, ad, a, d, bw, sel && wr);
    check(dq_oe, sel && !wr && !oe_n);
    if (sel && !wr && !oe_n) check(dq_out, mem[ea[5:0]]);
    if (($random(seed) & 3) == 0) begin
      hold_dq = dq_out;
      hold_oe = dq_oe;
      ctl.stall();
      check({hold_oe, dq_out}, {dq_oe, hold_dq});
    end
  endtask : op
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({dq_oe, dq_out}, 19'h00000);
    for (int i = 0; i < 64; i++) begin
      q = $random(seed);
      op(3'b010, 1'b0, 1'b0, 18'(i), q[17:0], 2'h0);
    end
    repeat (6) op(3'b000, 1'b1, 1'b0, 18'h00000, 18'h00000, 2'h3);
    op(3'b010, 1'b0, 1'b0, 18'h00005, 18'h2a5a5, 2'h2);
    op(3'b010, 1'b1, 1'b0, 18'h00005, 18'h00000, 2'h3);
    op(3'b010, 1'b0, 1'b0, 18'h3fffe, 18'h15555, 2'h1);
    repeat (3) op(3'b010, 1'b0, 1'b1, 18'h00000, 18'h0ab12, 2'h0);
    op(3'b010, 1'b1, 1'b0, 18'h0003e, 18'h00000, 2'h3);
    repeat (3) op(3'b010, 1'b1, 1'b1, 18'h3ffff, 18'h00000, 2'h3);
    // Modes: linear, interleaved, then output enable held off
    for (int m = 0; m < 3; m++) begin
      inter = m[0];
      oe_n = m[1];
      repeat (6) op(3'b000, 1'b1, 1'b0, 18'h00000, 18'h00000, 2'h3);
      repeat (150) begin
        r = $random(seed);
        q = $random(seed);
        op(r[2:0] == 3'h0 ? dsel[r[4:3]] : 3'b010, r[6], r[7], r[25:8], q[17:0], r[27:26]);
      end
    end
    summarize();
  end
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : flow_through_burst_sram_port_test
